// [rtl/ntsf_pkg.sv]
// package for the non-temporal store, prefetch and store fence block
// assumes one core clock; all widths and codes are shared by every file
package ntsf_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 128;
   localparam int BYTES_W = DATA_W / 8;
   localparam int QW_W = 64;
   localparam int QW_BYTES = QW_W / 8;
   localparam int PF_BLOCK_BYTES = 32;
   localparam int PF_OFS_W = $clog2(PF_BLOCK_BYTES);
   localparam int CSR_W = 32;
   localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_1f80;
   localparam logic [BYTES_W-1:0] MASK_NONE = '0;
   localparam logic [BYTES_W-1:0] MASK_QW = 16'h00ff;
   localparam logic [BYTES_W-1:0] MASK_ALL = 16'hffff;

   typedef enum logic [2:0] {
      NTSF_OP_NONE,
      NTSF_OP_CSR_LOAD,
      NTSF_OP_CSR_STORE,
      NTSF_OP_NT_QW,
      NTSF_OP_NT_PS,
      NTSF_OP_MASKED,
      NTSF_OP_PREFETCH,
      NTSF_OP_FENCE
   } ntsf_op_t;

   typedef enum logic [1:0] {
      NTSF_HINT_T0,
      NTSF_HINT_T1,
      NTSF_HINT_T2,
      NTSF_HINT_NTA
   } ntsf_hint_t;

   typedef enum logic [2:0] {
      NTSF_MT_UC,
      NTSF_MT_WC,
      NTSF_MT_WT,
      NTSF_MT_WP,
      NTSF_MT_WB
   } ntsf_mtype_t;

   // target level of a cache fill, nearer levels have lower codes
   typedef enum logic [1:0] {
      NTSF_LVL_NONE,
      NTSF_LVL_ONE,
      NTSF_LVL_TWO
   } ntsf_lvl_t;

   typedef struct packed {
      ntsf_op_t              op;
      ntsf_hint_t            hint;
      ntsf_mtype_t           mtype;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     data;
      logic [QW_BYTES-1:0]   bmask;
   } ntsf_req_t;

   typedef struct packed {
      logic                  valid;
      logic                  nt;
      ntsf_mtype_t           mtype;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     data;
      logic [BYTES_W-1:0]    be;
   } ntsf_wr_t;

   typedef struct packed {
      logic                  valid;
      logic [ADDR_W-1:0]     addr;
      ntsf_lvl_t             level;
      logic                  nt;
   } ntsf_pf_t;
endpackage

// [rtl/ntsf_wc_buf.sv]
// one write-combining buffer: gathers non-temporal bytes of one line
// assumes the parent drains it when told and holds drain until accepted
`timescale 1ns/1ps
module ntsf_wc_buf
   import ntsf_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 merge_en,
   input  wire logic                 wr_en,
   input  wire logic [ADDR_W-1:0]    wr_addr,
   input  wire logic [DATA_W-1:0]    wr_data,
   input  wire logic [BYTES_W-1:0]   wr_be,
   input  wire logic                 drain,
   input  wire logic                 drain_ack,
   output logic                      busy,
   output logic                      hit,
   output logic [ADDR_W-1:0]         line_addr,
   output logic [DATA_W-1:0]         line_data,
   output logic [BYTES_W-1:0]        line_be
);
   localparam int OFS_W = $clog2(BYTES_W);

   logic                 busy_r, busy_nxt;
   logic [ADDR_W-1:0]    addr_r, addr_nxt;
   logic [DATA_W-1:0]    data_r, data_nxt;
   logic [BYTES_W-1:0]   be_r, be_nxt;

   assign hit = busy_r && merge_en && (addr_r[ADDR_W-1:OFS_W] == wr_addr[ADDR_W-1:OFS_W]);
   assign busy = busy_r;
   assign line_addr = addr_r;
   assign line_data = data_r;
   assign line_be = be_r;

   always_comb begin
      busy_nxt = busy_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      be_nxt = be_r;
      if (drain && drain_ack) begin
         busy_nxt = 1'b0;
         be_nxt = MASK_NONE;
      end
      // a missing line loads in the same cycle the old one leaves
      if (wr_en) begin
         // on a hit only selected lanes change, others keep older merged bytes
         for (int i = 0; i < BYTES_W; i++) begin
            if (wr_be[i]) begin
               data_nxt[i*8 +: 8] = wr_data[i*8 +: 8];
            end
         end
         be_nxt = (hit ? be_r : MASK_NONE) | wr_be;
         data_nxt = hit ? data_nxt : (wr_data & {DATA_W{1'b1}});
         addr_nxt = {wr_addr[ADDR_W-1:OFS_W], {OFS_W{1'b0}}};
         busy_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         addr_r <= '0;
         data_r <= '0;
         be_r <= MASK_NONE;
      end else begin
         busy_r <= busy_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         be_r <= be_nxt;
      end
   end
endmodule

// [rtl/ntsf_top.sv]
// memory-side sequencer for non-temporal stores, prefetch, store fence and csr moves
// assumes requests come from the pipeline one at a time under req_valid/req_ready
//
// Overview of operation
// - csr load fills register; store writes it out
// - nt store to wb/wt/wc evicts cached copies
// - nt stores combine, no allocate, weakly ordered
// - nt stores may merge into one write
// - uc or wp type overrides nt hint
// - masked store writes only selected bytes
// - quadword and packed-single nt stores to memory
// - prefetch fetches aligned 32-byte block at hint
// - no movement when nearer level already holds
// - prefetch never changes architectural results
// - t0 hint fills every cache level
// - t1/t2 hints fill level two and up
// - nta hint fills near, minimal pollution
// - later accesses follow the prefetch temporality
// - fence orders older stores before younger ones
`timescale 1ns/1ps
module ntsf_top
   import ntsf_pkg::*;
#(
   parameter bit MERGE_EN = 1'b1
)
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire ntsf_req_t            req,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire logic [CSR_W-1:0]     csr_load_data,
   output logic [CSR_W-1:0]          csr_value,
   output logic                      csr_store_valid,
   output logic [ADDR_W-1:0]         csr_store_addr,
   input  wire logic                 l1_present,
   input  wire logic                 l2_present,
   output ntsf_wr_t                  mem_wr,
   input  wire logic                 mem_wr_ack,
   output logic                      evict_valid,
   output logic [ADDR_W-1:0]         evict_addr,
   output ntsf_pf_t                  pf_out,
   output logic                      fence_busy
);
   typedef enum logic [1:0] {ST_IDLE, ST_FENCE} ntsf_state_t;

   ntsf_state_t          state_r, state_nxt;
   logic [CSR_W-1:0]     csr_r, csr_nxt;
   logic                 csr_st_r, csr_st_nxt;
   logic [ADDR_W-1:0]    csr_addr_r, csr_addr_nxt;
   ntsf_wr_t             wr_r, wr_nxt;
   logic                 ev_r, ev_nxt;
   logic [ADDR_W-1:0]    ev_addr_r, ev_addr_nxt;
   ntsf_pf_t             pf_r, pf_nxt;
   logic                 fb_r, fb_nxt;
   logic                 rdy_r, rdy_nxt;

   logic                 take;
   logic                 is_nt;
   logic                 nt_cacheable;
   logic [BYTES_W-1:0]   nt_be;
   logic [DATA_W-1:0]    nt_data;
   logic                 wc_wr;
   logic                 wc_drain;
   logic                 wc_busy;
   logic                 wc_hit;
   logic [ADDR_W-1:0]    wc_addr;
   logic [DATA_W-1:0]    wc_data;
   logic [BYTES_W-1:0]   wc_be;
   logic                 wr_pend;

   assign take = req_valid && rdy_r;
   assign is_nt = (req.op == NTSF_OP_NT_QW) || (req.op == NTSF_OP_NT_PS) || (req.op == NTSF_OP_MASKED);
   assign nt_cacheable = (req.mtype == NTSF_MT_WB) || (req.mtype == NTSF_MT_WT) ||
                         (req.mtype == NTSF_MT_WC);
   assign wr_pend = wr_r.valid && !mem_wr_ack;

   // byte enables per store kind
   always_comb begin
      nt_data = req.data;
      case (req.op)
         NTSF_OP_NT_QW: nt_be = MASK_QW;
         NTSF_OP_NT_PS: nt_be = MASK_ALL;
         NTSF_OP_MASKED: nt_be = {{(BYTES_W-QW_BYTES){1'b0}}, req.bmask};
         default: nt_be = MASK_NONE;
      endcase
   end

   // new line that misses the buffer forces the old line out first
   assign wc_drain = wc_busy && ((state_r == ST_FENCE) ||
                     (take && is_nt && nt_cacheable && !wc_hit));
   assign wc_wr = take && is_nt && nt_cacheable;

   ntsf_wc_buf u_wc (
      .mclk      (mclk),
      .rst       (rst),
      .merge_en  (MERGE_EN),
      .wr_en     (wc_wr),
      .wr_addr   (req.addr),
      .wr_data   (nt_data),
      .wr_be     (nt_be),
      .drain     (wc_drain && !wr_pend),
      .drain_ack (1'b1),
      .busy      (wc_busy),
      .hit       (wc_hit),
      .line_addr (wc_addr),
      .line_data (wc_data),
      .line_be   (wc_be)
   );

   always_comb begin
      state_nxt = state_r;
      csr_nxt = csr_r;
      csr_st_nxt = 1'b0;
      csr_addr_nxt = csr_addr_r;
      wr_nxt = wr_r;
      ev_nxt = 1'b0;
      ev_addr_nxt = ev_addr_r;
      pf_nxt = '0;
      fb_nxt = fb_r;
      rdy_nxt = 1'b1;
      if (wr_r.valid && mem_wr_ack) begin
         wr_nxt.valid = 1'b0;
      end
      // buffered line leaves once the write port is free
      if (wc_drain && !wr_pend) begin
         wr_nxt.valid = 1'b1;
         wr_nxt.nt = 1'b1;
         wr_nxt.mtype = NTSF_MT_WC;
         wr_nxt.addr = wc_addr;
         wr_nxt.data = wc_data;
         wr_nxt.be = wc_be;
      end
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               case (req.op)
                  NTSF_OP_CSR_LOAD: csr_nxt = csr_load_data;
                  NTSF_OP_CSR_STORE: begin
                     csr_st_nxt = 1'b1;
                     csr_addr_nxt = req.addr;
                  end
                  NTSF_OP_NT_QW, NTSF_OP_NT_PS, NTSF_OP_MASKED: begin
                     if (nt_cacheable) begin
                        ev_nxt = 1'b1;
                        ev_addr_nxt = req.addr;
                     end else begin
                        // strong type: direct ordered write, no combining
                        wr_nxt.valid = 1'b1;
                        wr_nxt.nt = 1'b0;
                        wr_nxt.mtype = req.mtype;
                        wr_nxt.addr = req.addr;
                        wr_nxt.data = nt_data;
                        wr_nxt.be = nt_be;
                     end
                  end
                  NTSF_OP_PREFETCH: begin
                     // pure cache fill, no architectural state touched
                     pf_nxt.addr = {req.addr[ADDR_W-1:PF_OFS_W], {PF_OFS_W{1'b0}}};
                     pf_nxt.nt = (req.hint == NTSF_HINT_NTA);
                     case (req.hint)
                        NTSF_HINT_T0: begin
                           pf_nxt.level = NTSF_LVL_ONE;
                           pf_nxt.valid = !l1_present;
                        end
                        NTSF_HINT_T1, NTSF_HINT_T2: begin
                           pf_nxt.level = NTSF_LVL_TWO;
                           pf_nxt.valid = !(l1_present || l2_present);
                        end
                        NTSF_HINT_NTA: begin
                           pf_nxt.level = NTSF_LVL_ONE;
                           pf_nxt.valid = !l1_present;
                        end
                        default: pf_nxt.valid = 1'b0;
                     endcase
                  end
                  NTSF_OP_FENCE: begin
                     fb_nxt = 1'b1;
                     state_nxt = ST_FENCE;
                  end
                  default: ;
               endcase
            end
         end
         ST_FENCE: begin
            if (!wc_busy && !wr_r.valid) begin
               fb_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // younger requests stall while a fence waits for older stores to leave
      if (state_nxt != ST_IDLE) begin
         rdy_nxt = 1'b0;
      end
      // ready only with the write port free, so a taken store never waits
      if (wr_nxt.valid) begin
         rdy_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         csr_r <= CSR_RESET;
         csr_st_r <= 1'b0;
         csr_addr_r <= '0;
         wr_r <= '0;
         ev_r <= 1'b0;
         ev_addr_r <= '0;
         pf_r <= '0;
         fb_r <= 1'b0;
         rdy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         csr_r <= csr_nxt;
         csr_st_r <= csr_st_nxt;
         csr_addr_r <= csr_addr_nxt;
         wr_r <= wr_nxt;
         ev_r <= ev_nxt;
         ev_addr_r <= ev_addr_nxt;
         pf_r <= pf_nxt;
         fb_r <= fb_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   assign req_ready = rdy_r;
   assign csr_value = csr_r;
   assign csr_store_valid = csr_st_r;
   assign csr_store_addr = csr_addr_r;
   assign mem_wr = wr_r;
   assign evict_valid = ev_r;
   assign evict_addr = ev_addr_r;
   assign pf_out = pf_r;
   assign fence_busy = fb_r;
endmodule

// [test/ntsf_top_properties.sv]
// port checker for ntsf_top
// assumes one clock, async active-high reset; bound below
`timescale 1ns/1ps
module ntsf_top_chk
   import ntsf_pkg::*;
#(
   parameter bit MERGE_EN = 1'b1
)
(
   input wire logic             mclk,
   input wire logic             rst,
   input wire ntsf_req_t        req,
   input wire logic             req_valid,
   input wire logic             req_ready,
   input wire logic [CSR_W-1:0] csr_load_data,
   input wire logic [CSR_W-1:0] csr_value,
   input wire logic             csr_store_valid,
   input wire logic [ADDR_W-1:0] csr_store_addr,
   input wire logic             l1_present,
   input wire logic             l2_present,
   input wire ntsf_wr_t         mem_wr,
   input wire logic             mem_wr_ack,
   input wire logic             evict_valid,
   input wire ntsf_pf_t         pf_out,
   input wire logic             fence_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic tk, pf, st, t12;
   assign tk = req_valid && req_ready;
   assign pf = tk && req.op == NTSF_OP_PREFETCH;
   assign st = tk && req.op inside {NTSF_OP_NT_QW, NTSF_OP_NT_PS, NTSF_OP_MASKED};
   assign t12 = req.hint inside {NTSF_HINT_T1, NTSF_HINT_T2};
   property p_csr_ld; tk && req.op == NTSF_OP_CSR_LOAD |=> csr_value == $past(csr_load_data); endproperty
   a_csr_ld: assert property (p_csr_ld) else $error("csr load");
   property p_csr_st; tk && req.op == NTSF_OP_CSR_STORE |=> csr_store_valid && csr_store_addr == $past(req.addr); endproperty
   a_csr_st: assert property (p_csr_st) else $error("csr store");
   property p_evict; st && req.mtype inside {NTSF_MT_WB, NTSF_MT_WT, NTSF_MT_WC} |=> evict_valid; endproperty
   a_evict: assert property (p_evict) else $error("no evict");
   property p_uc; st && req.mtype inside {NTSF_MT_UC, NTSF_MT_WP} |=> !evict_valid; endproperty
   a_uc: assert property (p_uc) else $error("uc evict");
   property p_noalloc; st |=> !pf_out.valid; endproperty
   a_noalloc: assert property (p_noalloc) else $error("store fetched line");
   property p_align; pf_out.valid |-> pf_out.addr[4:0] == 5'h00; endproperty
   a_align: assert property (p_align) else $error("prefetch align");
   property p_t0; pf && req.hint == NTSF_HINT_T0 && !l1_present |=> pf_out.valid && pf_out.level == NTSF_LVL_ONE; endproperty
   a_t0: assert property (p_t0) else $error("t0 level");
   property p_t12; pf && t12 && !l1_present && !l2_present |=>
      pf_out.valid && pf_out.level == NTSF_LVL_TWO && !pf_out.nt; endproperty
   a_t12: assert property (p_t12) else $error("t1 t2 level");
   property p_skip; pf && t12 && l1_present |=> !pf_out.valid; endproperty
   a_skip: assert property (p_skip) else $error("needless prefetch");
   property p_nta; pf && req.hint == NTSF_HINT_NTA && !l1_present |=> pf_out.valid && pf_out.nt; endproperty
   a_nta: assert property (p_nta) else $error("nta flag");
   property p_fence; fence_busy |-> !req_ready; endproperty
   a_fence: assert property (p_fence) else $error("fence lets younger in");
   property p_hold; mem_wr.valid && !mem_wr_ack |=> mem_wr.valid && $stable(mem_wr.addr); endproperty
   a_hold: assert property (p_hold) else $error("write dropped");
endmodule
bind ntsf_top ntsf_top_chk #(.MERGE_EN(MERGE_EN)) u_chk (.mclk, .rst, .req, .req_valid, .req_ready,
   .csr_load_data, .csr_value, .csr_store_valid, .csr_store_addr, .l1_present, .l2_present, .mem_wr, .mem_wr_ack,
   .evict_valid, .pf_out, .fence_busy);

// [test/ntsf_mem_model.sv]
// memory and cache-tag model on the far side of ntsf_top
// assumes presence is decoded from address bits 12 and 13
`timescale 1ns/1ps
module ntsf_mem_model
   import ntsf_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire ntsf_wr_t          mem_wr,
   input  wire logic [ADDR_W-1:0] look_addr,
   output logic                   mem_wr_ack,
   output logic                   l1_present,
   output logic                   l2_present
);
   logic [1:0] wait_r;
   logic [1:0] cnt_r;
   assign l1_present = look_addr[12];
   assign l2_present = look_addr[13];
   // varying accept delay of 1 to 4 cycles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mem_wr_ack <= 1'b0;
         wait_r <= 2'h0;
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         mem_wr_ack <= 1'b0;
         if (mem_wr.valid && !mem_wr_ack) begin
            if (wait_r == 2'h0) begin
               mem_wr_ack <= 1'b1;
               wait_r <= cnt_r;
            end else begin
               wait_r <= wait_r - 2'h1;
            end
         end
      end
   end
endmodule

// [test/tb_top.sv]
// self-checking bench for ntsf_top with a reference model
// assumes ntsf_mem_model answers writes and tag lookups
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("ERROR %0t: got %0h exp %0h", $time, a, b); end end
module tb_top
   import ntsf_pkg::*;
;
   logic             mclk = 0, rst = 1, req_valid = 0;
   logic             req_ready, csr_store_valid, l1_present, l2_present, mem_wr_ack, evict_valid, fence_busy;
   ntsf_req_t        req = '0, pr;
   logic [CSR_W-1:0] csr_load_data = '0, csr_value, csr_exp, pld;
   logic [ADDR_W-1:0] csr_store_addr, evict_addr;
   ntsf_wr_t         mem_wr, bf, nw, q[$];
   ntsf_pf_t         pf_out;
   logic [DATA_W-1:0] m;
   logic [31:0]      r;
   logic             pt, pl1, pl2, pb, t12;
   integer           fails = 0, compares = 0, cyc = 0, seed = 32'hfc1b, k;
   always #2 mclk = ~mclk;
   ntsf_top #(.MERGE_EN(1'b1)) DUT (.mclk(mclk), .rst(rst), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .csr_load_data(csr_load_data), .csr_value(csr_value),
      .csr_store_valid(csr_store_valid), .csr_store_addr(csr_store_addr), .l1_present(l1_present),
      .l2_present(l2_present), .mem_wr(mem_wr), .mem_wr_ack(mem_wr_ack), .evict_valid(evict_valid),
      .evict_addr(evict_addr), .pf_out(pf_out), .fence_busy(fence_busy));
   ntsf_mem_model u_mem (.mclk(mclk), .rst(rst), .mem_wr(mem_wr), .look_addr(req.addr),
      .mem_wr_ack(mem_wr_ack), .l1_present(l1_present), .l2_present(l2_present));
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic send(ntsf_op_t op, ntsf_hint_t h, ntsf_mtype_t mt, logic [ADDR_W-1:0] a);
      req <= '{op, h, mt, a, {$random(seed), $random(seed), $random(seed), $random(seed)}, 8'($random(seed)) | 8'h01};
      req_valid <= 1'b1;
      do @(posedge mclk); while (req_ready !== 1'b1);
   endtask
   // reference model: checks outputs one cycle after each take
   always @(posedge mclk) begin
      if (rst) begin
         pt = 0; pb = 0; bf = '0; csr_exp = CSR_RESET; q.delete();
      end else begin
         if (pt) case (pr.op)
            NTSF_OP_CSR_LOAD: begin
               `CHK(csr_value, pld)
               csr_exp = pld;
            end
            NTSF_OP_CSR_STORE: begin
               `CHK(csr_store_valid, 1'b1)
               `CHK(csr_value, csr_exp)
            end
            NTSF_OP_PREFETCH: begin
               t12 = pr.hint inside {NTSF_HINT_T1, NTSF_HINT_T2};
               `CHK(pf_out.valid, t12 ? !(pl1 || pl2) : !pl1)
               if (pf_out.valid) begin
                  `CHK(pf_out.addr, pr.addr & ~32'h1f)
                  `CHK(pf_out.level, t12 ? NTSF_LVL_TWO : NTSF_LVL_ONE)
                  `CHK(pf_out.nt, pr.hint == NTSF_HINT_NTA)
               end
            end
            NTSF_OP_FENCE: begin
               if (bf.valid) q.push_back(bf);
               bf.valid = 0;
            end
            default: begin
               nw = '{1'b1, 1'b1, pr.mtype, pr.addr & ~32'hf, pr.data, pr.op == NTSF_OP_NT_PS ? MASK_ALL :
                      pr.op == NTSF_OP_NT_QW ? MASK_QW : BYTES_W'(pr.bmask)};
               if (pr.mtype inside {NTSF_MT_UC, NTSF_MT_WP}) begin
                  `CHK(evict_valid, 1'b0)
                  nw.nt = 0;
                  q.push_back(nw);
               end else begin
                  `CHK(evict_valid, 1'b1)
                  `CHK(evict_addr[31:4], pr.addr[31:4])
                  if (bf.valid && bf.addr != nw.addr) begin
                     q.push_back(bf);
                     bf.valid = 0;
                  end
                  if (!bf.valid) bf = nw;
                  else for (k = 0; k < BYTES_W; k++) if (nw.be[k]) begin
                     bf.be[k] = 1'b1;
                     bf.data[8*k+:8] = nw.data[8*k+:8];
                  end
               end
            end
         endcase
         if (pb && !fence_busy) `CHK(q.size(), 0)
         // combined-line memory type is not compared
         if (mem_wr.valid && mem_wr_ack) begin
            k = -1;
            foreach (q[i]) if (k < 0 && q[i].addr == (mem_wr.addr & ~32'hf)) k = i;
            `CHK(k >= 0, 1'b1)
            if (k >= 0) begin
               for (int i = 0; i < BYTES_W; i++) m[8*i+:8] = {8{q[k].be[i]}};
               `CHK(mem_wr.be, q[k].be)
               `CHK(mem_wr.data & m, q[k].data & m)
               `CHK(mem_wr.nt, q[k].nt)
               q.delete(k);
            end
         end
         pt = req_valid && req_ready; pr = req; pl1 = l1_present; pld = csr_load_data; pb = fence_busy;
         pl2 = l2_present;
         cyc++;
         if (cyc == 5000) begin
            fails++;
            report_and_stop();
         end
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      `CHK(csr_value, CSR_RESET)
      send(NTSF_OP_CSR_STORE, NTSF_HINT_T0, NTSF_MT_WB, 32'h100);
      csr_load_data <= $random(seed);
      send(NTSF_OP_CSR_LOAD, NTSF_HINT_T0, NTSF_MT_WB, 32'h104);
      send(NTSF_OP_CSR_STORE, NTSF_HINT_T0, NTSF_MT_WB, 32'h108);
      for (int h = 0; h < 4; h++) for (int p = 0; p < 2; p++) if (p == 0 || h == 1 || h == 2)
         send(NTSF_OP_PREFETCH, ntsf_hint_t'(h), NTSF_MT_WB, ($random(seed) & 32'h0fff_efff) | (p << 12));
      repeat (3) begin
         repeat (14) begin
            r = $random(seed);
            send(r[1:0] == 0 ? NTSF_OP_MASKED : r[1] ? NTSF_OP_NT_PS : NTSF_OP_NT_QW, NTSF_HINT_T0,
                 ntsf_mtype_t'(r[4:2] % 5), (r[4:2] % 5 == 0 || r[4:2] % 5 == 3) ? 32'h100000 | (r[7:6] << 4) :
                 (r[5] ? 32'h40 : 32'h50));
         end
         send(NTSF_OP_FENCE, NTSF_HINT_T0, NTSF_MT_WB, 32'h0);
      end
      req_valid <= 1'b0;
      repeat (20) @(posedge mclk);
      report_and_stop();
   end
endmodule
